// ==== pkg/ctp_pkg.sv ====
// Constants of the cascadable timer pair: register map, fields, resets.
// Assumes one 20 MHz system clock and a 32-bit AXI4-Lite master.
// How it works
// - Cascade bit joins both timers into 32 bits
// - Lower word low half, upper word high half
// - Upper control ignored while cascaded, except its stop-in-idle bit
// - Cascade uses lower clock, upper interrupt flag
// - Period pair forms 32-bit match value
// - Count pair readable at any time
// - On bit starts and stops the counting
// - Stop-in-idle halts the timer during idle
// - Gate accumulates internal time, ignored when external
// - Prescale codes divide by 1, 8, 64, 256
// - Lower source bit picks pin edges or clock
// - Upper source bit picks pin edges or clock
// - Cascade idle run needs upper stop-in-idle clear
// - Single timers count synchronously, never asynchronously
// - Cascade also counts external edges in 32 bits
// - Counts feed capture/compare; cascade triggers converter
// - Unimplemented control bits read zero, ignore writes
package ctp_pkg;
	localparam int          AW           = 6;
	localparam logic [5:0]  OFF_LO_CTL   = 6'h00;
	localparam logic [5:0]  OFF_HI_CTL   = 6'h04;
	localparam logic [5:0]  OFF_LO_CNT   = 6'h08;
	localparam logic [5:0]  OFF_HI_CNT   = 6'h0C;
	localparam logic [5:0]  OFF_LO_PER   = 6'h10;
	localparam logic [5:0]  OFF_HI_PER   = 6'h14;
	localparam logic [5:0]  OFF_STAT     = 6'h18;
	localparam logic [5:0]  OFF_MASK     = 6'h1C;
	localparam int          B_ON         = 15;
	localparam int          B_SIDL       = 13;
	localparam int          B_GATE       = 6;
	localparam int          B_PS         = 4;
	localparam int          B_CASC       = 3;
	localparam int          B_CSRC       = 1;
	localparam int          IRQ_LO       = 0;
	localparam int          IRQ_HI       = 1;
	localparam logic [15:0] LO_CTL_WMASK = 16'hA07A;
	localparam logic [15:0] HI_CTL_WMASK = 16'hA072;
	localparam logic [15:0] CTL_RST      = 16'h0000;
	localparam logic [15:0] CNT_RST      = 16'h0000;
	localparam logic [15:0] PER_RST      = 16'hFFFF;
	localparam logic [1:0]  PS_1         = 2'h0;
	localparam logic [1:0]  PS_8         = 2'h1;
	localparam logic [1:0]  PS_64        = 2'h2;
	localparam int          PS_W         = 8;
	localparam logic [7:0]  DIV1_M1      = 8'h00;
	localparam logic [7:0]  DIV8_M1      = 8'h07;
	localparam logic [7:0]  DIV64_M1     = 8'h3F;
	localparam logic [7:0]  DIV256_M1    = 8'hFF;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// ==== pkg/ctp_reg_if.sv ====
// Register access carrier between the bus slave and the timer registers.
// Assumes one clock; read data is combinational from the read address.
interface ctp_reg_if;
	logic        wr_en;
	logic [5:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_err;
	logic [5:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_err;
	modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
	              input wr_err, rd_data, rd_err);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
	              output wr_err, rd_data, rd_err);
endinterface

// ==== core/ctp_axil_slave.sv ====
// AXI4-Lite slave turning bus transfers into single-cycle register strobes.
// Assumes one write and one read outstanding at most.
module ctp_axil_slave (
	input  wire logic                   sys_clk_i,
	input  wire logic                   reset_i,
	input  wire logic                   awvalid_i,
	output logic                        awready_o,
	input  wire logic [ctp_pkg::AW-1:0] awaddr_i,
	input  wire logic                   wvalid_i,
	output logic                        wready_o,
	input  wire logic [31:0]            wdata_i,
	input  wire logic [3:0]             wstrb_i,
	output logic                        bvalid_o,
	input  wire logic                   bready_i,
	output logic [1:0]                  bresp_o,
	input  wire logic                   arvalid_i,
	output logic                        arready_o,
	input  wire logic [ctp_pkg::AW-1:0] araddr_i,
	output logic                        rvalid_o,
	input  wire logic                   rready_i,
	output logic [31:0]                 rdata_o,
	output logic [1:0]                  rresp_o,
	ctp_reg_if.bus                      rif
);
	import ctp_pkg::*;
	logic          aw_got;
	logic          w_got;
	logic [AW-1:0] aw_addr;
	logic [31:0]   w_data;
	logic [3:0]    w_strb;
	logic          do_wr;

	assign do_wr       = aw_got & w_got & ~bvalid_o;
	assign rif.wr_en   = do_wr;
	assign rif.wr_addr = aw_addr;
	assign rif.wr_data = w_data;
	assign rif.wr_strb = w_strb;
	assign rif.rd_addr = araddr_i;

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			awready_o <= 1'b1;
			aw_got <= 1'b0;
			aw_addr <= '0;
		end else if (awvalid_i && awready_o) begin
			awready_o <= 1'b0;
			aw_got <= 1'b1;
			aw_addr <= awaddr_i;
		end else if (do_wr) begin
			aw_got <= 1'b0;
		end else if (bvalid_o && bready_i) begin
			awready_o <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wready_o <= 1'b1;
			w_got <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (wvalid_i && wready_o) begin
			wready_o <= 1'b0;
			w_got <= 1'b1;
			w_data <= wdata_i;
			w_strb <= wstrb_i;
		end else if (do_wr) begin
			w_got <= 1'b0;
		end else if (bvalid_o && bready_i) begin
			wready_o <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			bvalid_o <= 1'b0;
			bresp_o <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid_o <= 1'b1;
			bresp_o <= rif.wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (bready_i) begin
			bvalid_o <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			arready_o <= 1'b1;
			rvalid_o <= 1'b0;
			rdata_o <= '0;
			rresp_o <= RESP_OKAY;
		end else if (arvalid_i && arready_o) begin
			arready_o <= 1'b0;
			rvalid_o <= 1'b1;
			rdata_o <= rif.rd_data;
			rresp_o <= rif.rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (rvalid_o && rready_i) begin
			rvalid_o <= 1'b0;
			arready_o <= 1'b1;
		end
	end
endmodule // ctp_axil_slave

// ==== core/ctp_count_src.sv ====
// Count source of one timer: pin synchronisers, gate, prescaler, tick.
// Assumes pins are asynchronous to sys_clk_i and slower than half its rate.
module ctp_count_src (
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,
	input  wire logic       ext_clk_pin_i,
	input  wire logic       gate_pin_i,
	input  wire logic       run_i,
	input  wire logic       clk_sel_i,
	input  wire logic       gate_en_i,
	input  wire logic [1:0] prescale_i,
	output logic            tick_o
);
	import ctp_pkg::*;
	logic            ext_s1, ext_s2, ext_d;
	logic            gate_s1, gate_s2;
	logic [PS_W-1:0] pcnt;
	logic [PS_W-1:0] div_m1;
	logic            in_event;
	logic            ps_done;

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			{ext_s1, ext_s2, ext_d, gate_s1, gate_s2} <= 5'h00;
		end else begin
			{ext_s1, ext_s2, ext_d} <= {ext_clk_pin_i, ext_s1, ext_s2};
			{gate_s1, gate_s2} <= {gate_pin_i, gate_s1};
		end
	end

	always_comb begin
		case (prescale_i)
			PS_1:    div_m1 = DIV1_M1;
			PS_8:    div_m1 = DIV8_M1;
			PS_64:   div_m1 = DIV64_M1;
			default: div_m1 = DIV256_M1;
		endcase
	end

	// Pin edges are only counted after synchronising: no asynchronous mode
	assign in_event = clk_sel_i ? (ext_s2 & ~ext_d) : (~gate_en_i | gate_s2);
	assign ps_done  = pcnt >= div_m1;

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pcnt <= '0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= run_i & in_event & ps_done;
			if (!run_i) begin
				pcnt <= '0;
			end else if (in_event) begin
				pcnt <= ps_done ? '0 : pcnt + 1'b1;
			end
		end
	end

	a_gate_block: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		$past(run_i && !clk_sel_i && gate_en_i && !gate_s2) |-> !tick_o)
		else $error("tick while gate closed");
	a_ps8_space: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		tick_o && prescale_i == PS_8 |=> (!tick_o || prescale_i != PS_8)[*7])
		else $error("divide by 8 ticks too close");
endmodule // ctp_count_src

// ==== core/ctp_timer_pair.sv ====
// Top of the cascadable timer pair: registers, counters, interrupt.
// Assumes an AXI4-Lite master on sys_clk_i and an idle level from power logic.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
module ctp_timer_pair (
	input  wire logic                   sys_clk_i,
	input  wire logic                   reset_i,
	input  wire logic                   s_axi_awvalid_i,
	output logic                        s_axi_awready_o,
	input  wire logic [ctp_pkg::AW-1:0] s_axi_awaddr_i,
	input  wire logic                   s_axi_wvalid_i,
	output logic                        s_axi_wready_o,
	input  wire logic [31:0]            s_axi_wdata_i,
	input  wire logic [3:0]             s_axi_wstrb_i,
	output logic                        s_axi_bvalid_o,
	input  wire logic                   s_axi_bready_i,
	output logic [1:0]                  s_axi_bresp_o,
	input  wire logic                   s_axi_arvalid_i,
	output logic                        s_axi_arready_o,
	input  wire logic [ctp_pkg::AW-1:0] s_axi_araddr_i,
	output logic                        s_axi_rvalid_o,
	input  wire logic                   s_axi_rready_i,
	output logic [31:0]                 s_axi_rdata_o,
	output logic [1:0]                  s_axi_rresp_o,
	input  wire logic                   lower_ext_clock_pin_i,
	input  wire logic                   upper_ext_clock_pin_i,
	input  wire logic                   lower_gate_pin_i,
	input  wire logic                   upper_gate_pin_i,
	input  wire logic                   idle_i,
	output logic                        irq_o,
	output logic                        adc_trigger_o,
	output logic [15:0]                 lower_count_o,
	output logic [15:0]                 upper_count_o
);
	import ctp_pkg::*;

	// ==========================================================
	// Declarations
	logic [15:0] lower_timer_control;
	logic [15:0] upper_timer_control;
	logic [15:0] lower_count;
	logic [15:0] upper_count;
	logic [15:0] lower_period;
	logic [15:0] upper_period;
	logic [1:0]  irq_status;
	logic [1:0]  irq_mask;
	logic        cascade_select;
	logic        lo_run;
	logic        hi_run;
	logic        tick_lo;
	logic        tick_hi;
	logic [31:0] count32;
	logic [31:0] period32;
	logic        casc_match;
	logic        lo_match;
	logic        hi_match;
	logic        casc_wrap;
	logic        lo_wrap;
	logic        hi_wrap;
	logic [1:0]  next_set;
	logic [1:0]  next_clr;
	logic [15:0] wr_word;
	logic        wr_lo_ctl, wr_hi_ctl;
	logic        wr_lo_cnt, wr_hi_cnt;
	logic        wr_lo_per, wr_hi_per;
	logic        wr_stat, wr_mask;

	ctp_reg_if rif ();

	// ==========================================================
	// Bus slave
	ctp_axil_slave u_slave (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.awvalid_i (s_axi_awvalid_i),
		.awready_o (s_axi_awready_o),
		.awaddr_i  (s_axi_awaddr_i),
		.wvalid_i  (s_axi_wvalid_i),
		.wready_o  (s_axi_wready_o),
		.wdata_i   (s_axi_wdata_i),
		.wstrb_i   (s_axi_wstrb_i),
		.bvalid_o  (s_axi_bvalid_o),
		.bready_i  (s_axi_bready_i),
		.bresp_o   (s_axi_bresp_o),
		.arvalid_i (s_axi_arvalid_i),
		.arready_o (s_axi_arready_o),
		.araddr_i  (s_axi_araddr_i),
		.rvalid_o  (s_axi_rvalid_o),
		.rready_i  (s_axi_rready_i),
		.rdata_o   (s_axi_rdata_o),
		.rresp_o   (s_axi_rresp_o),
		.rif       (rif)
	);

	// ==========================================================
	// Write decode
	// Only byte lanes 0 and 1 exist; upper lanes are dropped
	assign wr_word   = {rif.wr_strb[1] ? rif.wr_data[15:8] : 8'h00,
	                    rif.wr_strb[0] ? rif.wr_data[7:0] : 8'h00};
	assign wr_lo_ctl = rif.wr_en && rif.wr_addr == OFF_LO_CTL;
	assign wr_hi_ctl = rif.wr_en && rif.wr_addr == OFF_HI_CTL;
	assign wr_lo_cnt = rif.wr_en && rif.wr_addr == OFF_LO_CNT;
	assign wr_hi_cnt = rif.wr_en && rif.wr_addr == OFF_HI_CNT;
	assign wr_lo_per = rif.wr_en && rif.wr_addr == OFF_LO_PER;
	assign wr_hi_per = rif.wr_en && rif.wr_addr == OFF_HI_PER;
	assign wr_stat   = rif.wr_en && rif.wr_addr == OFF_STAT;
	assign wr_mask   = rif.wr_en && rif.wr_addr == OFF_MASK;

	always_comb begin
		case (rif.wr_addr)
			OFF_LO_CTL, OFF_HI_CTL, OFF_LO_CNT, OFF_HI_CNT,
			OFF_LO_PER, OFF_HI_PER, OFF_STAT, OFF_MASK: rif.wr_err = 1'b0;
			default: rif.wr_err = 1'b1;
		endcase
	end

	// Helper keeping unwritten byte lanes of a register
	function automatic logic [15:0] lane_merge(input logic [15:0] old,
	                                           input logic [15:0] nw,
	                                           input logic [3:0]  strb);
		lane_merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction

	// ==========================================================
	// Control and period registers
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			lower_timer_control <= CTL_RST;
		end else if (wr_lo_ctl) begin
			lower_timer_control <= lane_merge(lower_timer_control, wr_word,
			                                  rif.wr_strb) & LO_CTL_WMASK;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			upper_timer_control <= CTL_RST;
		end else if (wr_hi_ctl) begin
			upper_timer_control <= lane_merge(upper_timer_control, wr_word,
			                                  rif.wr_strb) & HI_CTL_WMASK;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			lower_period <= PER_RST;
			upper_period <= PER_RST;
		end else begin
			if (wr_lo_per) begin
				lower_period <= lane_merge(lower_period, wr_word, rif.wr_strb);
			end
			if (wr_hi_per) begin
				upper_period <= lane_merge(upper_period, wr_word, rif.wr_strb);
			end
		end
	end

	// ==========================================================
	// Run control
	assign cascade_select = lower_timer_control[B_CASC];
	// Cascaded pair halts in idle if either stop-in-idle bit is set
	assign lo_run = lower_timer_control[B_ON] & ~(idle_i & (lower_timer_control[B_SIDL] |
	                (cascade_select & upper_timer_control[B_SIDL])));
	assign hi_run = upper_timer_control[B_ON] & ~cascade_select &
	                ~(idle_i & upper_timer_control[B_SIDL]);

	// Lower source serves the cascaded pair too
	ctp_count_src u_src_lo (
		.sys_clk_i     (sys_clk_i),
		.reset_i       (reset_i),
		.ext_clk_pin_i (lower_ext_clock_pin_i),
		.gate_pin_i    (lower_gate_pin_i),
		.run_i         (lo_run),
		.clk_sel_i     (lower_timer_control[B_CSRC]),
		.gate_en_i     (lower_timer_control[B_GATE]),
		.prescale_i    (lower_timer_control[B_PS+:2]),
		.tick_o        (tick_lo)
	);

	// Internal rate is the system clock, which is the instruction clock
	ctp_count_src u_src_hi (
		.sys_clk_i     (sys_clk_i),
		.reset_i       (reset_i),
		.ext_clk_pin_i (upper_ext_clock_pin_i),
		.gate_pin_i    (upper_gate_pin_i),
		.run_i         (hi_run),
		.clk_sel_i     (upper_timer_control[B_CSRC]),
		.gate_en_i     (upper_timer_control[B_GATE]),
		.prescale_i    (upper_timer_control[B_PS+:2]),
		.tick_o        (tick_hi)
	);

	// ==========================================================
	// Counters
	assign count32    = {upper_count, lower_count};
	assign period32   = {upper_period, lower_period};
	assign casc_match = count32 == period32;
	assign lo_match   = lower_count == lower_period;
	assign hi_match   = upper_count == upper_period;
	assign casc_wrap  = cascade_select & tick_lo & casc_match;
	assign lo_wrap    = ~cascade_select & tick_lo & lo_match;
	assign hi_wrap    = ~cascade_select & tick_hi & hi_match;

	// A software write to a count wins over a tick in the same cycle
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			lower_count <= CNT_RST;
		end else if (wr_lo_cnt) begin
			lower_count <= lane_merge(lower_count, wr_word, rif.wr_strb);
		end else if (casc_wrap || lo_wrap) begin
			lower_count <= CNT_RST;
		end else if (tick_lo) begin
			lower_count <= lower_count + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			upper_count <= CNT_RST;
		end else if (wr_hi_cnt) begin
			upper_count <= lane_merge(upper_count, wr_word, rif.wr_strb);
		end else if (casc_wrap || hi_wrap) begin
			upper_count <= CNT_RST;
		end else if (cascade_select) begin
			if (tick_lo && lower_count == 16'hFFFF) begin
				upper_count <= upper_count + 16'h0001;
			end
		end else if (tick_hi) begin
			upper_count <= upper_count + 16'h0001;
		end
	end

	// ==========================================================
	// Interrupt status and mask
	assign next_set = {casc_wrap | hi_wrap, lo_wrap};
	assign next_clr = wr_stat ? wr_word[1:0] : 2'h0;

	// Set wins over a clear arriving in the same cycle
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_status <= 2'h0;
		end else begin
			irq_status <= (irq_status & ~next_clr) | next_set;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_mask <= 2'h0;
		end else if (wr_mask) begin
			irq_mask <= wr_word[1:0];
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_o <= 1'b0;
			adc_trigger_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status & irq_mask);
			adc_trigger_o <= casc_wrap;
		end
	end

	assign lower_count_o = lower_count;
	assign upper_count_o = upper_count;

	// ==========================================================
	// Read mux
	always_comb begin
		rif.rd_data = 32'h0000_0000;
		rif.rd_err = 1'b0;
		case (rif.rd_addr)
			OFF_LO_CTL: rif.rd_data[15:0] = lower_timer_control;
			OFF_HI_CTL: rif.rd_data[15:0] = upper_timer_control;
			OFF_LO_CNT: rif.rd_data[15:0] = lower_count;
			OFF_HI_CNT: rif.rd_data[15:0] = upper_count;
			OFF_LO_PER: rif.rd_data[15:0] = lower_period;
			OFF_HI_PER: rif.rd_data[15:0] = upper_period;
			OFF_STAT:   rif.rd_data[1:0] = irq_status;
			OFF_MASK:   rif.rd_data[1:0] = irq_mask;
			default:    rif.rd_err = 1'b1;
		endcase
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	a_ctl_reserved: assert property (
		(lower_timer_control & ~LO_CTL_WMASK) == 16'h0000 &&
		(upper_timer_control & ~HI_CTL_WMASK) == 16'h0000)
		else $error("reserved control bit set");
	a_casc_wrap: assert property (
		cascade_select && tick_lo && casc_match && !wr_lo_cnt && !wr_hi_cnt
		|=> count32 == 32'h0000_0000 && irq_status[IRQ_HI])
		else $error("cascaded match did not restart");
	a_casc_flag: assert property (
		cascade_select && tick_lo && casc_match |=> irq_status[IRQ_HI])
		else $error("cascaded match did not set upper flag");
	a_casc_carry: assert property (
		cascade_select && tick_lo && !casc_match && lower_count == 16'hFFFF &&
		!wr_lo_cnt && !wr_hi_cnt
		|=> lower_count == 16'h0000 && upper_count == $past(upper_count) + 16'h0001)
		else $error("carry into upper word lost");
	a_upper_ignored: assert property (
		cascade_select && !tick_lo && !wr_hi_cnt |=> $stable(upper_count))
		else $error("upper word moved without lower tick");
	a_indep_count: assert property (
		!cascade_select && tick_lo && !lo_match && !wr_lo_cnt
		|=> lower_count == $past(lower_count) + 16'h0001 &&
		    ($stable(upper_count) || $past(tick_hi || wr_hi_cnt)))
		else $error("independent lower count wrong");
	a_off_hold: assert property (
		!lower_timer_control[B_ON] && !wr_lo_cnt ##1 !wr_lo_cnt
		|=> $stable(lower_count))
		else $error("lower timer counted while off");
	a_idle_halt: assert property (
		idle_i && cascade_select && upper_timer_control[B_SIDL] ##1
		!wr_lo_cnt |=> $stable(lower_count))
		else $error("cascaded timer ran in idle");
	a_lo_wrap_flag: assert property (
		!cascade_select && tick_lo && lo_match && !wr_lo_cnt
		|=> lower_count == 16'h0000 && irq_status[IRQ_LO] ##1
		    irq_o == $past(irq_mask[IRQ_LO]) || $past(irq_mask[IRQ_HI]))
		else $error("lower match did not restart and flag");
	a_adc_cascade: assert property (
		adc_trigger_o |-> $past(cascade_select && tick_lo && casc_match))
		else $error("converter trigger without cascaded match");
	a_flag_sticky: assert property (
		irq_status[IRQ_LO] && !(wr_stat && wr_word[IRQ_LO]) |=> irq_status[IRQ_LO])
		else $error("lower flag lost without clear");
	a_hi_idle: assert property (
		idle_i && !cascade_select && upper_timer_control[B_SIDL] ##1
		!wr_hi_cnt && !cascade_select |=> $stable(upper_count))
		else $error("upper timer ran in idle");
	a_irq_off: assert property (
		irq_mask == 2'h0 |=> !irq_o)
		else $error("interrupt raised while all masked");
	a_casc_no_lo: assert property (
		cascade_select && !irq_status[IRQ_LO] |=> !irq_status[IRQ_LO])
		else $error("cascaded match raised lower flag");
endmodule // ctp_timer_pair

// ==== sim/ctp_timer_pair_tb.sv ====
// Self-checking bench of the cascadable timer pair, driven over AXI4-Lite.
// Assumes the package register map and that every wait below is bounded.
module ctp_timer_pair_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ctp_pkg::*;
	logic        sys_clk_i = 1'b0;
	logic        reset_i   = 1'b1;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [5:0]  awaddr  = 6'h00, araddr = 6'h00;
	logic [31:0] wdata   = 32'h0, rd, rdata;
	logic        lpin = 1'b0, upin = 1'b0, lgate = 1'b0, ugate = 1'b0, idle = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq, adc, seen;
	logic [1:0]  bresp, rresp, resp;
	logic [15:0] lcnt, ucnt, c0, c1;
	logic [31:0] seed = 32'h0C45;
	int          err_count = 0, n_tests = 0, t1, t3, k, n;

	always #25 sys_clk_i = ~sys_clk_i;

	ctp_timer_pair ctp_timer_pair_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .lower_ext_clock_pin_i(lpin),
		.upper_ext_clock_pin_i(upin), .lower_gate_pin_i(lgate), .upper_gate_pin_i(ugate),
		.idle_i(idle), .irq_o(irq), .adc_trigger_o(adc), .lower_count_o(lcnt),
		.upper_count_o(ucnt));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic int dv(input int c);
		return (c == 3) ? 256 : (c == 2) ? 64 : (c == 1) ? 8 : 1;
	endfunction
	task automatic end_of_test();
		if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, m, s, e);
		end
	endtask
	task automatic guard(input int i, input int lim);
		if (i >= lim) begin
			err_count++;
			$display("[FAIL] %0t wait ran out", $time);
			end_of_test();
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge sys_clk_i);
	endtask
	// Both halves offered together; each dropped once taken, response awaited
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		int i;
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge sys_clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		resp = bresp;
		guard(i, 40);
	endtask
	task automatic rdr(input logic [5:0] a);
		int i;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge sys_clk_i);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd = rdata;
		resp = rresp;
		guard(i, 40);
	endtask
	// Pins held three cycles each way so the synchronisers never miss an edge
	task automatic pls(input int p);
		repeat (p) begin
			lpin  <= 1'b1;
			upin  <= 1'b1;
			ugate <= seed[0];
			cyc(3);
			lpin <= 1'b0;
			upin <= 1'b0;
			cyc(3);
		end
		cyc(6);
	endtask
	// Period difference cancels the fixed start and interrupt latency
	task automatic meas(input int ps, input logic [15:0] per, output int t);
		wr(OFF_LO_PER, {16'h0, per});
		wr(OFF_LO_CNT, 32'h0);
		wr(OFF_STAT, 32'h3);
		wr(OFF_LO_CTL, 32'h8000 | (32'(ps) << B_PS));
		for (t = 0; t < 2000 && irq !== 1'b1; t++) cyc(1);
		guard(t, 2000);
		wr(OFF_LO_CTL, 32'h0);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		cyc(4);
		reset_i <= 1'b0;
		cyc(1);
		rdr(OFF_LO_CTL);
		chk(rd, 32'h0, "lower control reset");
		rdr(OFF_LO_PER);
		chk(rd, {16'h0, PER_RST}, "period reset");
		rdr(6'h20);
		chk(resp, RESP_SLVERR, "unmapped read");
		wr(6'h02, 32'hFFFF);
		chk(resp, RESP_SLVERR, "unaligned write");
		for (k = 0; k < 6; k++) begin
			c0 = 16'(xs()) & 16'h7FFF;
			wr(OFF_LO_CTL, {16'h0, c0});
			wr(OFF_HI_CTL, {16'h0, c0});
			rdr(OFF_LO_CTL);
			chk(rd, {16'h0, c0 & LO_CTL_WMASK}, "lower control bits");
			rdr(OFF_HI_CTL);
			chk(rd, {16'h0, c0 & HI_CTL_WMASK}, "upper control bits");
		end
		wr(OFF_LO_CTL, 32'h0);
		wr(OFF_HI_CTL, 32'h0);
		wr(OFF_MASK, 32'h3);
		for (k = 0; k < 4; k++) begin
			meas(k, 16'h0001, t1);
			meas(k, 16'h0003, t3);
			chk(t3 - t1, 2 * dv(k), "prescaled period");
		end
		rdr(OFF_STAT);
		chk(rd[1:0], 2'b01, "lower match flag");
		wr(OFF_STAT, 32'h1);
		rdr(OFF_STAT);
		chk(rd[1:0], 2'b00, "flag cleared");
		wr(OFF_LO_PER, 32'hFFFF);
		idle <= 1'b1;
		for (k = 0; k < 2; k++) begin
			wr(OFF_LO_CTL, 32'h8000 | (32'(1 - k) << B_SIDL));
			wr(OFF_HI_CTL, 32'h8000 | (32'(1 - k) << B_SIDL));
			cyc(5);
			c0 = lcnt;
			c1 = ucnt;
			cyc(20);
			chk(lcnt, c0 + 16'(20 * k), "idle halt");
			chk(ucnt, c1 + 16'(20 * k), "upper idle halt");
		end
		idle <= 1'b0;
		wr(OFF_LO_CTL, 32'h8040);
		cyc(5);
		c0 = lcnt;
		lgate <= 1'b1;
		cyc(13);
		lgate <= 1'b0;
		cyc(8);
		chk(lcnt, c0 + 16'h0D, "gated time");
		wr(OFF_HI_CTL, 32'h8042);
		wr(OFF_LO_CTL, 32'h8042);
		c0 = lcnt;
		c1 = ucnt;
		n = 1 + int'(xs() % 32'h7);
		pls(n);
		chk(lcnt, c0 + 16'(n), "lower pin edges");
		chk(ucnt, c1 + 16'(n), "upper pin edges");
		// ==========================================================
		// Cascaded pair, on bit set last
		wr(OFF_LO_CTL, 32'h0008);
		wr(OFF_HI_CTL, 32'h8030);
		wr(OFF_LO_CNT, 32'hFFF0);
		wr(OFF_HI_CNT, 32'h0);
		wr(OFF_LO_PER, 32'h5);
		wr(OFF_HI_PER, 32'h1);
		wr(OFF_STAT, 32'h3);
		wr(OFF_MASK, 32'h2);
		wr(OFF_LO_CTL, 32'h8008);
		for (k = 0; k < 40 && ucnt !== 16'h1; k++) cyc(1);
		guard(k, 40);
		chk(lcnt, 16'h0, "carry into upper word");
		seen = 1'b0;
		for (k = 0; k < 12 && irq !== 1'b1; k++) begin
			cyc(1);
			seen = seen | adc;
		end
		guard(k, 12);
		chk(ucnt, 16'h0, "32-bit match restart");
		chk(seen, 1'b1, "converter trigger");
		rdr(OFF_STAT);
		chk(rd[1:0], 2'b10, "upper flag only");
		wr(OFF_MASK, 32'h0);
		cyc(2);
		chk(irq, 1'b0, "masked interrupt");
		wr(OFF_HI_CTL, 32'h2000);
		idle <= 1'b1;
		cyc(3);
		c0 = lcnt;
		cyc(10);
		chk(lcnt, c0, "cascade idle halt");
		wr(OFF_HI_CTL, 32'h0);
		cyc(3);
		c0 = lcnt;
		cyc(10);
		chk(lcnt, c0 + 16'h0A, "cascade idle run");
		idle <= 1'b0;
		wr(OFF_LO_CTL, 32'h0);
		wr(OFF_LO_CNT, 32'hFFFE);
		wr(OFF_HI_CNT, 32'h0);
		wr(OFF_LO_CTL, 32'h800A);
		pls(3);
		wr(OFF_LO_CTL, 32'h0);
		rdr(OFF_LO_CNT);
		chk(rd, 32'h1, "cascade pin count low");
		rdr(OFF_HI_CNT);
		chk(rd, 32'h1, "cascade pin count high");
		end_of_test();
	end
endmodule // ctp_timer_pair_tb
